/* File: hdl/eid_defines.svh */
/*
 * Register offsets, field positions, reset values and widths of the
 * external interrupt edge/debounce front end.
 * Assumes inclusion by bare name from the design module.
 */
`ifndef EID_DEFINES_SVH
`define EID_DEFINES_SVH

`define EID_NPIN 16
`define EID_NCHAN 17
`define EID_NMI_IDX 16

`define EID_OFF_CTRL 8'h00
`define EID_OFF_MODE 8'h04
`define EID_OFF_DEBEN 8'h08
`define EID_OFF_SENSE 8'h0C
`define EID_OFF_FILT 8'h10
`define EID_OFF_FLAG 8'h14
`define EID_OFF_MASK 8'h18
`define EID_OFF_LEVEL 8'h1C

`define EID_CTRL_EN 0
`define EID_CTRL_RATE 1
`define EID_CTRL_THR 2
`define EID_CTRL_DIV_LSB 4
`define EID_CTRL_DIV_MSB 7
`define EID_CTRL_NMI_SENSE_LSB 8
`define EID_CTRL_NMI_SENSE_MSB 9
`define EID_CTRL_RESET 10'h000

`define EID_THR_LOW 4'h4
`define EID_THR_HIGH 4'h8
`define EID_DIV_W 16

`endif

/* File: hdl/eid_pkg.sv */
/*
 * Types of the external interrupt edge/debounce front end.
 * Assumes nothing of its surroundings.
 */
package eid_pkg;
   typedef enum logic [1:0] {
      EID_SENSE_NONE = 2'b00,
      EID_SENSE_RISE = 2'b01,
      EID_SENSE_FALL = 2'b10,
      EID_SENSE_BOTH = 2'b11
   } eid_sense_t;
endpackage

/* File: hdl/eid_edge_debounce.sv */
/*
 * Edge detection for sixteen external interrupt pins and one non-maskable pin,
 * majority filter and debouncer for the sixteen external pins, with a strobe register port.
 * Assumes asynchronous pins, one 200 MHz clock and a master that never
 * asserts read and write strobes together.
 */
`timescale 1ns/1ps
`include "eid_defines.svh"

// Function
// - In synchronous edge mode each pin and the non-maskable pin are sampled on the core clock.
// - In synchronous edge mode a flag is set when the newest sample differs from the one before in a direction the pin's sense selects.
// - While the enable bit is set and any pin uses synchronous mode the block requests the controller clock.
// - In asynchronous mode an edge sets the flag through the same clocked sample path and the clock is not requested for it.
// - Both edge modes keep working in the Idle and Standby sleep states.
// - A debounced pin runs its debouncer in the form chosen by its edge mode select bit.
// - The debouncer derives a slow tick from a programmable divider of the controller clock.
// - Debouncing takes effect only when the pin senses rising, falling or both edges.
// - A debounced pin never has its majority filter active at the same time.
// - Each pin keeps a valid level and a counter that, while its debouncer is active, counts up on ticks with a differing sample.
// - An equal sample clears the counter, checked every clock or on ticks by the rate bit.
// - Synchronous debouncing validates after 4 differing ticks, or 8 with the threshold bit set.
// - Asynchronous debouncing always validates after 4 differing ticks.
// - Software can read the level of every pin, debounced on pins whose debouncer is active.
module eid_edge_debounce (
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic [15:0] i_irq_input_pin,
   input wire logic i_nmi_pin,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output logic o_irq,
   output logic o_nmi,
   output logic o_clk_request
);

   function automatic logic sense_hit(input logic [1:0] s, input logic rise, input logic fall);
      sense_hit = (s[0] & rise) | (s[1] & fall);
   endfunction

   logic [9:0] ctrl_reg;
   logic [16:0] mode_reg;
   logic [15:0] deb_en_reg;
   logic [31:0] sense_reg;
   logic [15:0] filt_en_reg;
   logic [16:0] flag_reg;
   logic [16:0] mask_reg;
   logic [16:0] sync1_reg;
   logic [16:0] sync2_reg;
   logic [16:0] samp_a_reg;
   logic [16:0] samp_b_reg;
   logic [16:0] fprev_reg;
   logic [16:0] valid_reg;
   logic [3:0] cnt_reg [0:16];
   logic [15:0] div_reg;
   logic [31:0] rdata_next;

   wire ctrl_en = ctrl_reg[`EID_CTRL_EN];
   wire rate_tick_only = ctrl_reg[`EID_CTRL_RATE];
   wire thr_high = ctrl_reg[`EID_CTRL_THR];
   wire [3:0] div_sel = ctrl_reg[`EID_CTRL_DIV_MSB:`EID_CTRL_DIV_LSB];
   wire [15:0] div_mask = 16'(({1'b0, 16'hFFFF} >> (5'd15 - {1'b0, div_sel})));
   // Tick every 2^(div_sel+1) clocks; slow activity window set by software
   wire tick = ((div_reg & div_mask) == div_mask);

   wire wr_ctrl = i_wr & (i_addr == `EID_OFF_CTRL);
   wire wr_mode = i_wr & (i_addr == `EID_OFF_MODE);
   wire wr_deb = i_wr & (i_addr == `EID_OFF_DEBEN);
   wire wr_sense = i_wr & (i_addr == `EID_OFF_SENSE);
   wire wr_filt = i_wr & (i_addr == `EID_OFF_FILT);
   wire wr_flag = i_wr & (i_addr == `EID_OFF_FLAG);
   wire wr_mask = i_wr & (i_addr == `EID_OFF_MASK);
   wire [16:0] flag_clr = wr_flag ? i_wdata[16:0] : 17'h00000;

   logic [1:0] sense [0:16];
   logic [16:0] deb_act;
   logic [16:0] filt_act;
   logic [16:0] filt_val;
   logic [16:0] edge_set;
   logic [16:0] differ;
   logic [16:0] validate;
   logic [16:0] bounce;
   logic [3:0] thr [0:16];
   logic [16:0] valid_next;
   logic [3:0] cnt_next [0:16];

   genvar g;
   generate
      for (g = 0; g < `EID_NCHAN; g++)
      begin : g_chan
         if (g == `EID_NMI_IDX)
         begin : g_nmi
            assign sense[g] = ctrl_reg[`EID_CTRL_NMI_SENSE_MSB:`EID_CTRL_NMI_SENSE_LSB];
            assign deb_act[g] = 1'b0;
            assign filt_act[g] = 1'b0;
         end
         else
         begin : g_ext
            assign sense[g] = sense_reg[2*g+1:2*g];
            assign deb_act[g] = deb_en_reg[g] & (sense[g] != eid_pkg::EID_SENSE_NONE);
            assign filt_act[g] = filt_en_reg[g] & ~deb_act[g];
         end
         // Majority of three samples when the filter is on
         assign filt_val[g] = filt_act[g] ?
            ((sync2_reg[g] & samp_a_reg[g]) | (sync2_reg[g] & samp_b_reg[g]) |
             (samp_a_reg[g] & samp_b_reg[g])) : sync2_reg[g];
         // Newest sample against the one before; same path in both edge modes
         assign edge_set[g] = sense_hit(sense[g], filt_val[g] & ~fprev_reg[g],
                                        ~filt_val[g] & fprev_reg[g]);
         assign differ[g] = sync2_reg[g] ^ valid_reg[g];
         assign thr[g] = (mode_reg[g] | ~thr_high) ? `EID_THR_LOW : `EID_THR_HIGH;
         assign validate[g] = deb_act[g] & tick & differ[g] & (cnt_reg[g] == thr[g] - 4'h1);
         assign bounce[g] = ~differ[g] & (rate_tick_only ? tick : 1'b1);
      end
   endgenerate

   wire [16:0] deb_set = validate & {sense_hit(sense[16], 1'b0, 1'b0),
      {16{1'b1}}} & {1'b0, 16'hFFFF};
   logic [16:0] set_ev;
   always_comb
   begin
      for (int i = 0; i < `EID_NCHAN; i++)
      begin
         // Validated edge is judged against the level it leaves
         set_ev[i] = ctrl_en & (deb_act[i] ?
            (deb_set[i] & sense_hit(sense[i], ~valid_reg[i], valid_reg[i])) :
            edge_set[i]);
      end
   end

   // Set beats a simultaneous write-one clear
   wire [16:0] flag_next = (flag_reg & ~flag_clr) | set_ev;
   // No sleep input: detection never stops while the enable bit is set and the clock runs
   wire clk_req_next = ctrl_en & |(~mode_reg);
   wire irq_next = |(flag_next[15:0] & mask_reg[15:0]);

   always_comb
   begin
      case (i_addr)
         `EID_OFF_CTRL: rdata_next = {22'h000000, ctrl_reg};
         `EID_OFF_MODE: rdata_next = {15'h0000, mode_reg};
         `EID_OFF_DEBEN: rdata_next = {16'h0000, deb_en_reg};
         `EID_OFF_SENSE: rdata_next = sense_reg;
         `EID_OFF_FILT: rdata_next = {16'h0000, filt_en_reg};
         `EID_OFF_FLAG: rdata_next = {15'h0000, flag_reg};
         `EID_OFF_MASK: rdata_next = {15'h0000, mask_reg};
         `EID_OFF_LEVEL: rdata_next = {15'h0000, valid_reg};
         default: rdata_next = 32'h00000000;
      endcase
   end

   always_ff @(posedge i_core_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         ctrl_reg <= `EID_CTRL_RESET;
         mode_reg <= 17'h00000;
         deb_en_reg <= 16'h0000;
         sense_reg <= 32'h00000000;
         filt_en_reg <= 16'h0000;
         mask_reg <= 17'h00000;
      end
      else
      begin
         if (wr_ctrl) ctrl_reg <= i_wdata[9:0];
         if (wr_mode) mode_reg <= i_wdata[16:0];
         if (wr_deb) deb_en_reg <= i_wdata[15:0];
         if (wr_sense) sense_reg <= i_wdata;
         if (wr_filt) filt_en_reg <= i_wdata[15:0];
         if (wr_mask) mask_reg <= i_wdata[16:0];
      end
   end

   // Pins cross into the clock domain before any logic looks at them
   always_ff @(posedge i_core_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         sync1_reg <= 17'h00000;
         sync2_reg <= 17'h00000;
         samp_a_reg <= 17'h00000;
         samp_b_reg <= 17'h00000;
         fprev_reg <= 17'h00000;
         div_reg <= 16'h0000;
      end
      else
      begin
         sync1_reg <= {i_nmi_pin, i_irq_input_pin};
         sync2_reg <= sync1_reg;
         samp_a_reg <= sync2_reg;
         samp_b_reg <= samp_a_reg;
         fprev_reg <= filt_val;
         div_reg <= ctrl_en ? div_reg + 16'h0001 : 16'h0000;
      end
   end

   generate
      for (g = 0; g < `EID_NCHAN; g++)
      begin : g_deb
         assign valid_next[g] = !deb_act[g] ? filt_val[g] :
            (validate[g] ? sync2_reg[g] : valid_reg[g]);
         // Validation or a bounce restarts the count
         assign cnt_next[g] = (!deb_act[g] || validate[g] || bounce[g]) ? 4'h0 :
            ((tick & differ[g]) ? cnt_reg[g] + 4'h1 : cnt_reg[g]);
      end
   endgenerate

   // One process owns every channel's level and counter
   always_ff @(posedge i_core_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         valid_reg <= 17'h00000;
         cnt_reg <= '{default: 4'h0};
      end
      else
      begin
         valid_reg <= valid_next;
         cnt_reg <= cnt_next;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         flag_reg <= 17'h00000;
         o_irq <= 1'b0;
         o_nmi <= 1'b0;
         o_clk_request <= 1'b0;
         o_rdata <= 32'h00000000;
      end
      else
      begin
         flag_reg <= flag_next;
         o_irq <= irq_next;
         o_nmi <= flag_next[`EID_NMI_IDX];
         o_clk_request <= clk_req_next;
         o_rdata <= i_rd ? rdata_next : 32'h00000000;
      end
   end

   property p_sync_edge;
      @(posedge i_core_clk) disable iff (i_reset)
      (ctrl_en && !deb_act[0] && sense[0] == eid_pkg::EID_SENSE_BOTH &&
       filt_val[0] != fprev_reg[0]) |=> flag_reg[0];
   endproperty
   a_sync_edge: assert property (p_sync_edge) else $error("edge did not set flag");

   property p_clk_req;
      @(posedge i_core_clk) disable iff (i_reset)
      (ctrl_en && !mode_reg[0]) |=> o_clk_request;
   endproperty
   a_clk_req: assert property (p_clk_req) else $error("clock not requested");

   property p_async_noreq;
      @(posedge i_core_clk) disable iff (i_reset)
      (&mode_reg) |=> !o_clk_request;
   endproperty
   a_async_noreq: assert property (p_async_noreq)
      else $error("clock requested in async mode");

   // Debounce checks watch channel 1; channel 0 stays on the plain edge path
   property p_cnt_inc;
      @(posedge i_core_clk) disable iff (i_reset)
      (deb_act[1] && tick && differ[1] && !validate[1] && !bounce[1])
         |=> cnt_reg[1] == $past(cnt_reg[1]) + 4'h1;
   endproperty
   a_cnt_inc: assert property (p_cnt_inc) else $error("counter did not step");

   property p_bounce;
      @(posedge i_core_clk) disable iff (i_reset)
      (deb_act[1] && !rate_tick_only && !differ[1]) |=> cnt_reg[1] == 4'h0;
   endproperty
   a_bounce: assert property (p_bounce) else $error("bounce did not clear counter");

   property p_thr8;
      @(posedge i_core_clk) disable iff (i_reset)
      (deb_act[1] && !mode_reg[1] && thr_high && tick && differ[1] && cnt_reg[1] == 4'h6)
         |=> !validate[1] && cnt_reg[1] == 4'h7;
   endproperty
   a_thr8: assert property (p_thr8) else $error("validated before eight ticks");

   property p_async4;
      @(posedge i_core_clk) disable iff (i_reset)
      (deb_act[1] && mode_reg[1] && tick && differ[1] && cnt_reg[1] == 4'h3)
         |=> valid_reg[1] != $past(valid_reg[1]) && cnt_reg[1] == 4'h0;
   endproperty
   a_async4: assert property (p_async4) else $error("async threshold not four");

   property p_deb_excl;
      @(posedge i_core_clk) disable iff (i_reset)
      deb_act[1] |-> !filt_act[1];
   endproperty
   a_deb_excl: assert property (p_deb_excl) else $error("filter active with debouncer");

   property p_deb_sense;
      @(posedge i_core_clk) disable iff (i_reset)
      (sense[1] == eid_pkg::EID_SENSE_NONE) |-> !deb_act[1];
   endproperty
   a_deb_sense: assert property (p_deb_sense) else $error("debounce with no sense");

   property p_tick;
      @(posedge i_core_clk) disable iff (i_reset)
      (tick && !$changed(div_sel)) |=> !tick;
   endproperty
   a_tick: assert property (p_tick) else $error("tick longer than one cycle");

   property p_level;
      @(posedge i_core_clk) disable iff (i_reset)
      (i_rd && i_addr == `EID_OFF_LEVEL) |=> o_rdata[16:0] == $past(valid_reg);
   endproperty
   a_level: assert property (p_level) else $error("level readback wrong");

   property p_validate_flag;
      @(posedge i_core_clk) disable iff (i_reset)
      (ctrl_en && validate[1] && sense[1] == eid_pkg::EID_SENSE_BOTH)
         |=> (flag_reg[1] && cnt_reg[1] == 4'h0) ##1 (o_irq || !mask_reg[1]);
   endproperty
   a_validate_flag: assert property (p_validate_flag) else $error("validation lost");

   c_validate: cover property (@(posedge i_core_clk) disable iff (i_reset) validate[1]);
   c_nmi: cover property (@(posedge i_core_clk) disable iff (i_reset) o_nmi);
   c_set_clear: cover property (@(posedge i_core_clk) disable iff (i_reset)
      set_ev[0] && flag_clr[0]);

endmodule // eid_edge_debounce

/* File: tb/eid_pin_model.sv */
/*
 * Off-chip drivers of the sixteen interrupt pins and the non-maskable pin.
 * Assumes one core clock; levels change only just after a rising edge.
 */
`timescale 1ns/1ps
module eid_pin_model (
   input wire logic i_core_clk,
   output logic [15:0] o_pins,
   output logic o_nmi_pin
);
   initial
   begin
      o_pins = 16'h0000;
      o_nmi_pin = 1'b0;
   end

   // Index 16 is the non-maskable pin; bounces are built from short holds
   task automatic set_pin(input int idx, input logic val);
      @(posedge i_core_clk);
      if (idx == 16)
      begin
         o_nmi_pin <= val;
      end
      else
      begin
         o_pins[idx] <= val;
      end
   endtask
endmodule // eid_pin_model

/* File: tb/ext_irq_edge_debounce_tb_top.sv */
/*
 * Self-checking bench of the edge/debounce front end.
 * Assumes the strobe register port and the pin model beside it.
 */
`timescale 1ns/1ps
`include "eid_defines.svh"
module ext_irq_edge_debounce_tb_top;
   logic clk, rst, wr, rd;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, d;
   logic [15:0] pins;
   logic nmi_pin, irq, nmi, clk_req;
   int num_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   // Rows: sense of pin 0, new pin level, expected flag
   localparam logic [3:0] ROWS [8] = '{4'b0111, 4'b0100, 4'b1010, 4'b1001,
                                       4'b1111, 4'b1101, 4'b0010, 4'b0000};

   eid_pin_model i_eid_pin_model (.i_core_clk(clk), .o_pins(pins), .o_nmi_pin(nmi_pin));
   eid_edge_debounce i_eid_edge_debounce (.i_core_clk(clk), .i_reset(rst),
      .i_irq_input_pin(pins), .i_nmi_pin(nmi_pin), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .o_nmi(nmi),
      .o_clk_request(clk_req));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         close_out();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Data stand only in the cycle after the strobe
   task automatic rreg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask

   initial
   begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk({29'h0, irq, nmi, clk_req}, 32'h0);
      rreg(`EID_OFF_CTRL, d);
      chk(d, 32'h0000_0000);
      rreg(`EID_OFF_LEVEL, d);
      chk(d, 32'h0000_0000);
      $display("reset test done");

      wreg(`EID_OFF_CTRL, 32'h0000_0001);
      wreg(`EID_OFF_MASK, 32'h0000_0001);
      wreg(8'hF0, 32'hFFFF_FFFF);
      rreg(8'hF0, d);
      chk(d, 32'h0000_0000);
      rreg(`EID_OFF_MASK, d);
      chk(d, 32'h0000_0001);
      wt(2);
      chk({31'h0, clk_req}, 32'h1);
      wreg(`EID_OFF_MODE, 32'h0001_FFFF);
      wt(2);
      chk({31'h0, clk_req}, 32'h0);
      wreg(`EID_OFF_MODE, 32'h0000_0000);
      $display("config test done");

      foreach (ROWS[i])
      begin
         wreg(`EID_OFF_SENSE, {30'h0, ROWS[i][3:2]});
         i_eid_pin_model.set_pin(0, ROWS[i][1]);
         wt(6);
         rreg(`EID_OFF_FLAG, d);
         chk(d & 32'h1, {31'h0, ROWS[i][0]});
         chk({31'h0, irq}, {31'h0, ROWS[i][0]});
         wreg(`EID_OFF_FLAG, 32'h0000_0001);
      end
      $display("edge table done");

      // Masked-out flag must not reach the level interrupt
      wreg(`EID_OFF_SENSE, 32'h0000_0001);
      i_eid_pin_model.set_pin(0, 1'b1);
      wreg(`EID_OFF_MASK, 32'h0000_0000);
      wt(6);
      chk({31'h0, irq}, 32'h0);
      wreg(`EID_OFF_MASK, 32'h0000_0001);
      wt(2);
      chk({31'h0, irq}, 32'h1);
      wreg(`EID_OFF_FLAG, 32'h0000_0001);
      wt(2);
      chk({31'h0, irq}, 32'h0);
      wreg(`EID_OFF_CTRL, 32'h0000_0101);
      i_eid_pin_model.set_pin(16, 1'b1);
      wt(6);
      chk({31'h0, nmi}, 32'h1);
      wreg(`EID_OFF_FLAG, 32'h0001_0000);
      wt(2);
      chk({31'h0, nmi}, 32'h0);
      $display("interrupt test done");

      // Pin 1: both edges, debounced, filter request ignored, tick every 4 clocks
      wreg(`EID_OFF_SENSE, 32'h0000_000C);
      wreg(`EID_OFF_DEBEN, 32'h0000_0002);
      wreg(`EID_OFF_FILT, 32'h0000_0002);
      wreg(`EID_OFF_CTRL, 32'h0000_0017);
      i_eid_pin_model.set_pin(1, 1'b1);
      wt(3);
      i_eid_pin_model.set_pin(1, 1'b0);
      wt(30);
      rreg(`EID_OFF_FLAG, d);
      chk(d & 32'h2, 32'h0);
      i_eid_pin_model.set_pin(1, 1'b1);
      wt(22);
      rreg(`EID_OFF_LEVEL, d);
      chk(d & 32'h2, 32'h0);
      wt(30);
      rreg(`EID_OFF_LEVEL, d);
      chk(d & 32'h2, 32'h2);
      rreg(`EID_OFF_FLAG, d);
      chk(d & 32'h2, 32'h2);
      wreg(`EID_OFF_FLAG, 32'h0000_0002);
      wreg(`EID_OFF_MODE, 32'h0000_0002);
      i_eid_pin_model.set_pin(1, 1'b0);
      wt(22);
      rreg(`EID_OFF_LEVEL, d);
      chk(d & 32'h2, 32'h0);
      rreg(`EID_OFF_FLAG, d);
      chk(d & 32'h2, 32'h2);
      $display("debounce test done");

      // Pin 2: majority filter swallows a one-clock pulse, passes a held level
      wreg(`EID_OFF_SENSE, 32'h0000_001C);
      wreg(`EID_OFF_FILT, 32'h0000_0006);
      i_eid_pin_model.set_pin(2, 1'b1);
      i_eid_pin_model.set_pin(2, 1'b0);
      wt(8);
      rreg(`EID_OFF_FLAG, d);
      chk(d & 32'h4, 32'h0);
      i_eid_pin_model.set_pin(2, 1'b1);
      wt(8);
      rreg(`EID_OFF_FLAG, d);
      chk(d & 32'h4, 32'h4);
      // Pin 1 synchronous again, threshold 4, bounce checked every clock
      wreg(`EID_OFF_CTRL, 32'h0000_0011);
      wreg(`EID_OFF_MODE, 32'h0000_0000);
      i_eid_pin_model.set_pin(1, 1'b1);
      wt(12);
      rreg(`EID_OFF_LEVEL, d);
      chk(d & 32'h2, 32'h0);
      wt(10);
      rreg(`EID_OFF_LEVEL, d);
      chk(d & 32'h2, 32'h2);
      $display("filter and threshold test done");
      close_out();
   end
endmodule // ext_irq_edge_debounce_tb_top
